// ==== rtl/osm_regs.svh ====
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design files of this block
`ifndef OSM_REGS_SVH
`define OSM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OSM_A_WDATA     8'h00
`define OSM_A_ADDR      8'h04
`define OSM_A_CTRL      8'h06
`define OSM_A_STAT      8'h08
`define OSM_A_RDAT      8'h0a
`define OSM_A_SHADOW    8'h0e
`define OSM_A_IST       8'h20
`define OSM_A_IMASK     8'h22
`define OSM_A_WAKE      8'h24
`define OSM_A_PMC       8'h26

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OSM_C_MODE      0
`define OSM_C_READ      1
`define OSM_C_PROG      6
`define OSM_C_TRIG      15
`define OSM_S_DONE      0
`define OSM_S_VPP       1
`define OSM_I_LOAD      0
`define OSM_I_READ      1
`define OSM_I_PROG      2
`define OSM_W_AUTOLOAD  0
`define OSM_P_RUN       0
`define OSM_AW          11

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define OSM_SPECIAL_ADDR 11'h400
`define OSM_PMC_RST      1'b1
`define OSM_READ_CYC     8'h04
`define OSM_PROG_CYC     8'h14
`define OSM_UCODE_WORDS  64

`endif

// ==== rtl/osm_pkg.sv ====
// Types shared by the memory interface block
// Assumes nothing beyond a SystemVerilog compiler
package osm_pkg;
  typedef enum logic [1:0] {
    OSM_IDLE = 2'b00,
    OSM_BOOT = 2'b01,
    OSM_MRD  = 2'b11,
    OSM_PROG = 2'b10
  } osm_state_t;

  typedef enum logic [1:0] {
    OSM_OP_NONE = 2'b00,
    OSM_OP_READ = 2'b01,
    OSM_OP_PROG = 2'b10
  } osm_op_t;
endpackage : osm_pkg

// ==== rtl/osm_nvm_if.sv ====
// Request and answer bundle between controller and memory array
// Assumes one clock; req is a one-cycle pulse taken only when idle
`timescale 1ns/1ps
interface osm_nvm_if import osm_pkg::*; ();
  logic        req;
  osm_op_t     op;
  logic [10:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        done;

  modport ctrl (output req, op, addr, wdata, input rdata, done);
  modport mem  (input req, op, addr, wdata, output rdata, done);
endinterface : osm_nvm_if

// ==== rtl/osm_nvm_array.sv ====
// One-time-programmable word array with fixed read and program times
// Assumes the controller issues a request only after the previous done
`timescale 1ns/1ps
`include "osm_regs.svh"
module osm_nvm_array import osm_pkg::*; #(
  parameter int          WORDS    = 2048,
  parameter logic [7:0]  READ_CYC = `OSM_READ_CYC,
  parameter logic [7:0]  PROG_CYC = `OSM_PROG_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  osm_nvm_if.mem   nvm
);
  logic [31:0]      mem [WORDS];
  logic [WORDS-1:0] written;
  osm_op_t          op, next_op;
  logic [10:0]      a, next_a;
  logic [31:0]      wd, next_wd, rd;
  logic [7:0]       cnt, next_cnt;
  logic             dn, next_dn;
  logic             fin;

  assign fin       = (op != OSM_OP_NONE) && (cnt == 8'h00);
  assign nvm.rdata = rd;
  assign nvm.done  = dn;

  always_comb begin
    next_op  = op;
    next_a   = a;
    next_wd  = wd;
    next_cnt = cnt;
    next_dn  = 1'b0;
    if (op == OSM_OP_NONE) begin
      if (nvm.req) begin
        next_op  = nvm.op;
        next_a   = nvm.addr;
        next_wd  = nvm.wdata;
        next_cnt = (nvm.op == OSM_OP_PROG) ? PROG_CYC - 8'h01 : READ_CYC - 8'h01;
      end
    end else if (fin) begin
      next_op = OSM_OP_NONE;
      next_dn = 1'b1;
    end else begin
      next_cnt = cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op      <= OSM_OP_NONE;
      a       <= 11'h000;
      wd      <= 32'h0000_0000;
      cnt     <= 8'h00;
      dn      <= 1'b0;
      rd      <= 32'h0000_0000;
      written <= '0;
    end else begin
      op  <= next_op;
      a   <= next_a;
      wd  <= next_wd;
      cnt <= next_cnt;
      dn  <= next_dn;
      // Blank words read as zero; programming can only add one bits
      if (fin && op == OSM_OP_READ) rd <= written[a] ? mem[a] : 32'h0000_0000;
      if (fin && op == OSM_OP_PROG) written[a] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fin && op == OSM_OP_PROG) mem[a] <= (written[a] ? mem[a] : 32'h0000_0000) | wd;
  end
endmodule : osm_nvm_array

// ==== rtl/osm_microcode_loader.sv ====
// Copies edge-engine microcode from a constant table into its RAM
// Assumes start and flush are one-cycle pulses on the same clock
`timescale 1ns/1ps
module osm_microcode_loader #(
  parameter int WORDS = 64,
  parameter int AW    = $clog2(WORDS)
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_sync_n,
  input  wire logic          start,
  input  wire logic          flush,
  input  wire logic [AW-1:0] eng_addr,
  output logic               busy,
  output logic               done,
  output logic               code_valid,
  output logic [31:0]        eng_word
);
  logic [31:0]   ram [WORDS];
  logic [AW-1:0] idx, next_idx;
  logic          next_busy, next_done, next_valid;

  function automatic logic [31:0] osm_rom_word(input logic [AW-1:0] i);
    // Widen before inverting so the upper bits of the low byte come out set
    osm_rom_word = {8'ha5, 8'(i), 8'h3c, ~8'(i)};
  endfunction : osm_rom_word

  always_comb begin
    next_busy  = busy;
    next_idx   = idx;
    next_valid = code_valid;
    next_done  = 1'b0;
    if (flush) begin
      next_busy  = 1'b0;
      next_valid = 1'b0;
      next_idx   = '0;
    end else if (busy) begin
      if (idx == AW'(WORDS - 1)) begin
        next_busy  = 1'b0;
        next_valid = 1'b1;
        next_done  = 1'b1;
      end else begin
        next_idx = idx + 1'b1;
      end
    end else if (start) begin
      next_busy  = 1'b1;
      next_valid = 1'b0;
      next_idx   = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      busy       <= 1'b0;
      idx        <= '0;
      done       <= 1'b0;
      code_valid <= 1'b0;
    end else begin
      busy       <= next_busy;
      idx        <= next_idx;
      done       <= next_done;
      code_valid <= next_valid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (busy && !flush) ram[idx] <= osm_rom_word(idx);
    eng_word <= ram[eng_addr];
  end
endmodule : osm_microcode_loader

// ==== rtl/osm_top.sv ====
// Memory interface control: microcode load, status, read data, shadow word
// Assumes a single-cycle register port on clk_sys; pins are asynchronous
`timescale 1ns/1ps
`include "osm_regs.svh"

module osm_top import osm_pkg::*; #(
  parameter int UCODE_WORDS = `OSM_UCODE_WORDS,
  parameter int UAW         = $clog2(UCODE_WORDS)
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [31:0]    reg_rdata,
  input  wire logic           sleep_active,
  input  wire logic           vpp_ok,
  input  wire logic [UAW-1:0] ucode_rd_addr,
  output logic      [31:0]    ucode_rd_word,
  output logic                edge_engine_active,
  output logic                irq
);
  // --------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------
  logic rst_meta, rst_sync_n;
  logic slp_s1, slp_s2, slp_s3, vpp_s1, vpp_s2;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      slp_s1 <= 1'b0;
      slp_s2 <= 1'b0;
      slp_s3 <= 1'b0;
      vpp_s1 <= 1'b0;
      vpp_s2 <= 1'b0;
    end else begin
      slp_s1 <= sleep_active;
      slp_s2 <= slp_s1;
      slp_s3 <= slp_s2;
      vpp_s1 <= vpp_ok;
      vpp_s2 <= vpp_s1;
    end
  end

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  osm_nvm_if nvm ();
  logic ld_start, ld_flush, ld_busy, ld_done, code_valid;

  osm_nvm_array u_array (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .nvm        (nvm.mem)
  );

  osm_microcode_loader #(.WORDS(UCODE_WORDS), .AW(UAW)) u_loader (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .start      (ld_start),
    .flush      (ld_flush),
    .eng_addr   (ucode_rd_addr),
    .busy       (ld_busy),
    .done       (ld_done),
    .code_valid (code_valid),
    .eng_word   (ucode_rd_word)
  );

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  osm_state_t  st, next_st;
  osm_op_t     op, next_op;
  logic        req, next_req, boot_pend, next_boot_pend;
  logic [10:0] naddr, next_naddr, addr, next_addr;
  logic [31:0] wdata, next_wdata, rdat, next_rdat, shadow, next_shadow;
  logic        c_mode, next_c_mode, c_read, next_c_read;
  logic        c_prog, next_c_prog, prog_pend, next_prog_pend;
  logic        trig, next_trig, prog_done, next_prog_done;
  logic [2:0]  ist, next_ist, imask, next_imask, ev;
  logic        autoload, next_autoload, run_en, next_run_en;
  logic [31:0] next_reg_rdata;
  logic        next_irq, next_eng;
  logic        slp_entry, slp_exit;

  function automatic logic osm_hit(input logic s, input logic [7:0] a, input logic [7:0] o);
    osm_hit = s && (a == o);
  endfunction : osm_hit

  assign slp_entry = slp_s2 && !slp_s3;
  assign slp_exit  = !slp_s2 && slp_s3;
  assign ld_flush  = slp_entry;
  assign nvm.req   = req;
  assign nvm.op    = op;
  assign nvm.addr  = naddr;
  assign nvm.wdata = wdata;

  // Load start: software trigger or wake autoload; sleep entry wins
  always_comb begin
    ld_start = 1'b0;
    if (!trig && !slp_entry) begin
      if (osm_hit(reg_wr, reg_addr, `OSM_A_CTRL) && reg_wdata[`OSM_C_TRIG])
        ld_start = 1'b1;
      if (slp_exit && autoload) ld_start = 1'b1;
    end
  end

  always_comb begin
    next_st = st;  next_op = op;  next_req = 1'b0;  next_naddr = naddr;
    next_boot_pend = boot_pend;  next_addr = addr;  next_wdata = wdata;
    next_rdat = rdat;  next_shadow = shadow;  next_c_mode = c_mode;
    next_c_read = c_read;  next_c_prog = c_prog;  next_prog_pend = prog_pend;
    next_trig = trig;  next_prog_done = prog_done;  next_imask = imask;
    next_autoload = autoload;  next_run_en = run_en;
    ev = 3'b000;
    // Memory access sequencer; boot shadow read goes first
    case (st)
      OSM_IDLE: begin
        if (boot_pend) begin
          next_st = OSM_BOOT;  next_req = 1'b1;  next_op = OSM_OP_READ;
          next_naddr = `OSM_SPECIAL_ADDR;  next_boot_pend = 1'b0;
        end else if (c_read) begin
          next_st = OSM_MRD;  next_req = 1'b1;  next_op = OSM_OP_READ;
          next_naddr = addr;
        end else if (prog_pend) begin
          next_st = OSM_PROG;  next_req = 1'b1;  next_op = OSM_OP_PROG;
          next_naddr = addr;  next_prog_pend = 1'b0;
        end
      end
      OSM_BOOT: if (nvm.done) begin
        next_shadow = nvm.rdata;
        next_st = OSM_IDLE;
      end
      OSM_MRD: if (nvm.done) begin
        next_rdat = nvm.rdata;
        next_c_read = 1'b0;
        ev[`OSM_I_READ] = 1'b1;
        next_st = OSM_IDLE;
      end
      OSM_PROG: if (nvm.done) begin
        next_prog_done = 1'b1;
        ev[`OSM_I_PROG] = 1'b1;
        next_st = OSM_IDLE;
      end
      default: next_st = OSM_IDLE;
    endcase
    if (ld_done) begin
      next_trig = 1'b0;
      ev[`OSM_I_LOAD] = 1'b1;
    end
    if (slp_entry) next_trig = 1'b0;
    if (ld_start) next_trig = 1'b1;
    // Software writes; status register is hardware owned
    if (osm_hit(reg_wr, reg_addr, `OSM_A_WDATA)) next_wdata = reg_wdata;
    if (osm_hit(reg_wr, reg_addr, `OSM_A_ADDR)) next_addr = reg_wdata[`OSM_AW-1:0];
    if (osm_hit(reg_wr, reg_addr, `OSM_A_SHADOW)) next_shadow = reg_wdata;
    if (osm_hit(reg_wr, reg_addr, `OSM_A_IMASK)) next_imask = reg_wdata[2:0];
    if (osm_hit(reg_wr, reg_addr, `OSM_A_WAKE)) next_autoload = reg_wdata[`OSM_W_AUTOLOAD];
    if (osm_hit(reg_wr, reg_addr, `OSM_A_PMC)) next_run_en = reg_wdata[`OSM_P_RUN];
    if (osm_hit(reg_wr, reg_addr, `OSM_A_CTRL)) begin
      next_c_mode = reg_wdata[`OSM_C_MODE];
      next_c_prog = reg_wdata[`OSM_C_PROG];
      // Read command only counts in manual read mode
      if (reg_wdata[`OSM_C_READ] && reg_wdata[`OSM_C_MODE]) next_c_read = 1'b1;
      if (reg_wdata[`OSM_C_PROG] && !c_prog) begin
        next_prog_pend = 1'b1;
        if (!(st == OSM_PROG && nvm.done)) next_prog_done = 1'b0;
      end
    end
    // Read clears, a same-cycle event still lands
    next_ist = (osm_hit(reg_rd, reg_addr, `OSM_A_IST) ? 3'b000 : ist) | ev;
    next_irq = |(next_ist & next_imask);
    // Drop the engine in the cycle a reload starts, before the RAM is rewritten
    next_eng = run_en && code_valid && !slp_s2 && !ld_start;
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `OSM_A_WDATA:  next_reg_rdata = wdata;
        `OSM_A_ADDR:   next_reg_rdata = {21'h000000, addr};
        `OSM_A_CTRL:   next_reg_rdata = {16'h0000, trig, 8'h00, c_prog, 4'h0, c_read, c_mode};
        `OSM_A_STAT:   next_reg_rdata = {30'h0000_0000, vpp_s2, prog_done};
        `OSM_A_RDAT:   next_reg_rdata = rdat;
        `OSM_A_SHADOW: next_reg_rdata = shadow;
        `OSM_A_IST:    next_reg_rdata = {29'h0000_0000, ist};
        `OSM_A_IMASK:  next_reg_rdata = {29'h0000_0000, imask};
        `OSM_A_WAKE:   next_reg_rdata = {31'h0000_0000, autoload};
        `OSM_A_PMC:    next_reg_rdata = {31'h0000_0000, run_en};
        default:       next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= OSM_IDLE;  op <= OSM_OP_NONE;  req <= 1'b0;  naddr <= 11'h000;
      boot_pend <= 1'b1;  addr <= 11'h000;  wdata <= 32'h0000_0000;
      rdat <= 32'h0000_0000;  shadow <= 32'h0000_0000;  c_mode <= 1'b0;
      c_read <= 1'b0;  c_prog <= 1'b0;  prog_pend <= 1'b0;  trig <= 1'b0;
      prog_done <= 1'b0;  ist <= 3'b000;  imask <= 3'b000;  autoload <= 1'b0;
      run_en <= `OSM_PMC_RST;  reg_rdata <= 32'h0000_0000;  irq <= 1'b0;
      edge_engine_active <= 1'b0;
    end else begin
      st <= next_st;  op <= next_op;  req <= next_req;  naddr <= next_naddr;
      boot_pend <= next_boot_pend;  addr <= next_addr;  wdata <= next_wdata;
      rdat <= next_rdat;  shadow <= next_shadow;  c_mode <= next_c_mode;
      c_read <= next_c_read;  c_prog <= next_c_prog;  prog_pend <= next_prog_pend;
      trig <= next_trig;  prog_done <= next_prog_done;  ist <= next_ist;
      imask <= next_imask;  autoload <= next_autoload;  run_en <= next_run_en;
      reg_rdata <= next_reg_rdata;  irq <= next_irq;  edge_engine_active <= next_eng;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking osm_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  property p_trig_start;
    ld_start |=> trig ##1 ld_busy;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("load not started");

  property p_trig_clear;
    ld_done |=> !trig;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger stuck");

  property p_engine_code;
    edge_engine_active |-> $past(code_valid) && !ld_busy;
  endproperty
  a_engine_code: assert property (p_engine_code) else $error("engine without code");

  property p_autoload;
    slp_exit && autoload && !trig |=> trig;
  endproperty
  a_autoload: assert property (p_autoload) else $error("no autoload on wake");

  property p_engine_run;
    run_en && code_valid && !slp_s2 && !ld_start |=> edge_engine_active;
  endproperty
  a_engine_run: assert property (p_engine_run) else $error("engine idle");

  property p_prog_done;
    st == OSM_PROG && nvm.done |=> prog_done && st == OSM_IDLE;
  endproperty
  a_prog_done: assert property (p_prog_done) else $error("program done lost");

  property p_vpp;
    reg_rd && reg_addr == `OSM_A_STAT |=> reg_rdata[`OSM_S_VPP] == $past(vpp_s2);
  endproperty
  a_vpp: assert property (p_vpp) else $error("supply flag wrong");

  property p_read_data;
    st == OSM_MRD && nvm.done |=> rdat == $past(nvm.rdata) && !c_read;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_boot;
    st == OSM_BOOT |-> naddr == `OSM_SPECIAL_ADDR ##[1:300] st == OSM_IDLE;
  endproperty
  a_boot: assert property (p_boot) else $error("boot read stalled");

  property p_addr;
    req && st == OSM_MRD |-> naddr == addr;
  endproperty
  a_addr: assert property (p_addr) else $error("wrong word address");

  property p_reserved;
    reg_rd && reg_addr == `OSM_A_STAT |=> reg_rdata[31:2] == 30'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  c_load:  cover property (ld_start ##[1:100] ld_done);
  c_mread: cover property (st == OSM_MRD && nvm.done);
  c_pdone: cover property (st == OSM_PROG && nvm.done);
  c_wake:  cover property (slp_exit && autoload);
endmodule : osm_top

// ==== tb/osm_host_model.sv ====
// Host software model: register port master with one-cycle strobes
// Assumes the block answers a read in the cycle after the strobe
`timescale 1ns/1ps
module osm_host_model (
  input  wire logic        clk_sys,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
endmodule : osm_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the memory interface control block
// Assumes the memory array powers up blank (all words zero)
`timescale 1ns/1ps
`include "osm_regs.svh"
module tb;
  logic        clk_sys;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        sleep_active;
  logic        vpp_ok;
  logic [5:0]  ucode_rd_addr;
  logic [31:0] ucode_rd_word;
  logic        edge_engine_active;
  logic        irq;
  logic [31:0] d;
  int          failures;
  int          n_checks;

  osm_top osm_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_active(sleep_active), .vpp_ok(vpp_ok), .ucode_rd_addr(ucode_rd_addr),
    .ucode_rd_word(ucode_rd_word), .edge_engine_active(edge_engine_active), .irq(irq));
  osm_host_model osm_host_model_i (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ----------------------------------------------------------------
  // Shared checking
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task rd(input logic [7:0] a);
    osm_host_model_i.rd(a, d);
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] v);
    osm_host_model_i.wr(a, v);
  endtask : wr

  // Bounded poll on a register field
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 100; i++) begin
      rd(a);
      if ((d & m) === v) break;
    end
    chk(d & m, v);
  endtask : poll

  task wait_active(input logic v);
    for (int i = 0; i < 300; i++) begin
      // Look just after the edge so the flop's new value is seen
      @(posedge clk_sys) #1;
      if (edge_engine_active === v) break;
    end
    chk({31'h0, edge_engine_active}, {31'h0, v});
  endtask : wait_active

  task close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    rd(`OSM_A_STAT);   chk(d, 32'h0);
    rd(`OSM_A_CTRL);   chk(d, 32'h0);
    rd(`OSM_A_PMC);    chk(d, 32'h1);
    rd(`OSM_A_SHADOW); chk(d, 32'h0);
    rd(8'h40);         chk(d, 32'h0);
    chk({31'h0, edge_engine_active}, 32'h0);
  endtask : t_reset

  task t_prog();
    @(posedge clk_sys) vpp_ok <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(`OSM_A_STAT, 32'hffff);
    rd(`OSM_A_STAT); chk(d, 32'h2);
    wr(`OSM_A_WDATA, 32'h5a5ac3c3);
    wr(`OSM_A_ADDR, 32'h7ff);
    wr(`OSM_A_CTRL, 32'h40);
    poll(`OSM_A_STAT, 32'h1, 32'h1);
    wr(`OSM_A_CTRL, 32'h0);
    rd(`OSM_A_IST); chk(d, 32'h4);
  endtask : t_prog

  task t_read();
    // Bit 11 is outside the word address and must be dropped
    wr(`OSM_A_ADDR, 32'hfff);
    wr(`OSM_A_CTRL, 32'h2);
    rd(`OSM_A_CTRL); chk(d, 32'h0);
    wr(`OSM_A_CTRL, 32'h3);
    rd(`OSM_A_CTRL); chk(d & 32'h2, 32'h2);
    poll(`OSM_A_CTRL, 32'h2, 32'h0);
    rd(`OSM_A_RDAT); chk(d, 32'h5a5ac3c3);
    rd(`OSM_A_IST);  chk(d, 32'h2);
    wr(`OSM_A_CTRL, 32'h0);
  endtask : t_read

  task t_load();
    wr(`OSM_A_IMASK, 32'h1);
    wr(`OSM_A_CTRL, 32'h8000);
    rd(`OSM_A_CTRL); chk(d, 32'h8000);
    poll(`OSM_A_CTRL, 32'h8000, 32'h0);
    wait_active(1'b1);
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, irq}, 32'h1);
    @(posedge clk_sys) ucode_rd_addr <= 6'h05;
    repeat (2) @(posedge clk_sys);
    #1 chk(ucode_rd_word, 32'ha5053cfa);
    rd(`OSM_A_IST); chk(d, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, irq}, 32'h0);
    wr(`OSM_A_PMC, 32'h0);
    wait_active(1'b0);
    wr(`OSM_A_PMC, 32'h1);
    wait_active(1'b1);
  endtask : t_load

  task t_sleep(input logic auto);
    wr(`OSM_A_WAKE, {31'h0, auto});
    @(posedge clk_sys) sleep_active <= 1'b1;
    wait_active(1'b0);
    repeat (10) @(posedge clk_sys);
    @(posedge clk_sys) sleep_active <= 1'b0;
    if (auto) begin
      wait_active(1'b1);
      rd(`OSM_A_IST); chk(d, 32'h1);
    end else begin
      repeat (200) @(posedge clk_sys);
      #1 chk({31'h0, edge_engine_active}, 32'h0);
    end
  endtask : t_sleep

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Whole run needs about 500 cycles
  initial begin
    #(20000 * 100);
    failures++;
    close_out();
  end

  initial begin
    failures      = 0;
    n_checks      = 0;
    rst_n         = 1'b0;
    sleep_active  = 1'b0;
    vpp_ok        = 1'b0;
    ucode_rd_addr = 6'h00;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    t_reset();
    t_prog();
    t_read();
    t_load();
    t_sleep(1'b1);
    t_sleep(1'b0);
    close_out();
  end
endmodule : tb
